// >>> cdwp_pkg.sv
// Package for the character display write port: codes, geometry, timing.
// Assumes a single 200 MHz clock domain.
package cdwp_pkg;
  // Clock and serial timing
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned BAUD_SLOW = 1200;
  localparam int unsigned BAUD_FAST = 9600;
  localparam int unsigned BIT_CYC_SLOW = CLK_HZ / BAUD_SLOW;
  localparam int unsigned BIT_CYC_FAST = CLK_HZ / BAUD_FAST;
  localparam int unsigned PROC_CYC = 4; // Cycles of busy per byte
  // Geometry
  localparam int unsigned ROW_DIGITS = 20;
  localparam int unsigned ROWS = 2;
  localparam logic [5:0] POS_LAST = 6'h27;
  localparam logic [5:0] POS_ROW2 = 6'h14;
  localparam logic [5:0] POS_RESET = 6'h00;
  // Control codes
  localparam logic [7:0] CODE_FONT = 8'h03;
  localparam logic [7:0] CODE_BRIGHT = 8'h04;
  localparam logic [7:0] CODE_BS = 8'h08;
  localparam logic [7:0] CODE_TAB = 8'h09;
  localparam logic [7:0] CODE_CLEAR = 8'h0d;
  localparam logic [7:0] CODE_ALLON = 8'h0f;
  localparam logic [7:0] CODE_POS = 8'h10;
  localparam logic [7:0] CODE_CURSOR = 8'h17;
  localparam logic [7:0] CODE_RESET = 8'h1f;
  localparam logic [2:0] FONT_BYTES = 3'h6; // Slot code plus five font bytes
  // Brightness levels: 0 off .. 5 full
  localparam logic [2:0] BRIGHT_FULL = 3'h5;
  localparam logic [1:0] CURSOR_ON = 2'h1;
  localparam logic [1:0] CURSOR_OFF = 2'h0;
  localparam logic [1:0] CURSOR_BLINK = 2'h2;

  typedef enum logic [1:0] {
    CDWP_IDLE = 2'b00,
    CDWP_ARG = 2'b01,
    CDWP_FONT = 2'b11
  } cdwp_state_t;

  // One stored character event towards the drawing logic
  typedef struct packed {
    logic valid;
    logic clear_others;
    logic [5:0] pos;
    logic [7:0] code;
  } cdwp_char_t;
endpackage : cdwp_pkg

// >>> cdwp_write_port.sv
// Host write front end of a 2x20 character display module.
// Assumes asynchronous pins, synchronised here; one 200 MHz clock.
// Operation
// - Busy is high while a received byte is processed and low when another byte can be taken.
// - In parallel mode a byte is latched on the rising write strobe while select is low and test is high.
// - After each displayable character the write position moves one digit right.
// - With the test pin low the self-test runs and both host inputs are ignored.
// - Input comes either from the parallel port with select low or from the serial line.
// - The serial line runs at 1200 or 9600 bits per second as selected.
// - The write position covers 20 digits in each of 2 rows of 5x7 cells.
// - Six brightness levels are chosen by a host command.
// - Bytes 03,04,08,09,0d,0f,10,17,1f are control codes, not characters.
// - After the last digit of row two the position wraps to the first digit, and that write clears the rest.
// - The byte after the position command sets the position, 00-13 row one and 14-27 row two.
// - The byte after the brightness command sets the level: ff,80,60,40,20,00.
`timescale 1ns/1ps
`default_nettype none
module cdwp_write_port
  import cdwp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] data_pin,
  input wire logic write_n,
  input wire logic select_n,
  input wire logic test_n,
  input wire logic rxd,
  input wire logic baud_fast,
  output logic busy,
  output logic self_test,
  output cdwp_char_t char_out,
  output logic [5:0] write_pos,
  output logic [2:0] brightness,
  output logic [1:0] cursor_mode,
  output logic all_on,
  output logic clear_pulse
);

  // Two-stage synchronisers for every pin
  logic [12:0] sync1;
  logic [12:0] sync2;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1 <= 13'h1fff;
      sync2 <= 13'h1fff;
    end else begin
      sync1 <= {data_pin, write_n, select_n, test_n, rxd, baud_fast};
      sync2 <= sync1;
    end
  end
  logic [7:0] s_data;
  logic s_wr_n, s_sel_n, s_test_n, s_rxd, s_fast;
  assign {s_data, s_wr_n, s_sel_n, s_test_n, s_rxd, s_fast} = sync2;

  // Strobe edge; data is taken from the same synchroniser stage as the strobe, in the cycle the rise is seen
  logic wr_prev;
  always_ff @(posedge clk) begin
    if (!rstn) wr_prev <= 1'b1;
    else wr_prev <= s_wr_n;
  end
  logic par_take;
  assign par_take = !wr_prev && s_wr_n && !s_sel_n && s_test_n && !busy;

  // Serial receiver, 8N1; only listens when select is released
  logic [17:0] bit_cnt; // Slow bit time needs 18 bits
  logic [3:0] rx_bits;
  logic [7:0] rx_shift;
  logic rx_active, rx_done, rx_prev;
  logic [17:0] bit_len;
  assign bit_len = s_fast ? 18'(BIT_CYC_FAST) : 18'(BIT_CYC_SLOW);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_prev <= 1'b1;
      rx_active <= 1'b0;
      rx_done <= 1'b0;
      bit_cnt <= '0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
    end else begin
      rx_prev <= s_rxd;
      rx_done <= 1'b0;
      if (!s_test_n || !s_sel_n) begin
        rx_active <= 1'b0;
      end else if (!rx_active) begin
        if (rx_prev && !s_rxd) begin
          rx_active <= 1'b1;
          bit_cnt <= {1'b0, bit_len[17:1]}; // Sample mid-bit
          rx_bits <= 4'h0;
        end
      end else if (bit_cnt != 18'h0) begin
        bit_cnt <= bit_cnt - 18'h1;
      end else begin
        bit_cnt <= bit_len - 18'h1;
        rx_bits <= rx_bits + 4'h1;
        if (rx_bits == 4'h0 && s_rxd) rx_active <= 1'b0; // False start
        else if (rx_bits >= 4'h1 && rx_bits <= 4'h8) rx_shift <= {s_rxd, rx_shift[7:1]};
        else if (rx_bits == 4'h9) begin
          rx_active <= 1'b0;
          rx_done <= s_rxd; // Framing error drops the byte
        end
      end
    end
  end
  // Serial bytes arriving while busy are lost; no buffer by design
  logic ser_take;
  assign ser_take = rx_done && !busy && s_test_n;

  logic take;
  logic [7:0] in_byte;
  assign take = par_take || ser_take;
  assign in_byte = par_take ? s_data : rx_shift;
  assign self_test = !s_test_n;

  // Busy timer covers the processing of each byte
  logic [2:0] proc_cnt;
  always_ff @(posedge clk) begin
    if (!rstn) proc_cnt <= 3'h0;
    else if (take) proc_cnt <= 3'(PROC_CYC);
    else if (proc_cnt != 3'h0) proc_cnt <= proc_cnt - 3'h1;
  end
  assign busy = proc_cnt != 3'h0;

  // Command decoder
  cdwp_state_t state;
  logic [7:0] pend_cmd;
  logic [2:0] font_left;
  logic is_ctrl;
  always_comb begin
    case (in_byte)
      CODE_FONT, CODE_BRIGHT, CODE_BS, CODE_TAB, CODE_CLEAR,
      CODE_ALLON, CODE_POS, CODE_CURSOR, CODE_RESET: is_ctrl = 1'b1;
      default: is_ctrl = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= CDWP_IDLE;
      pend_cmd <= 8'h00;
      font_left <= 3'h0;
    end else if (take) begin
      case (state)
        CDWP_IDLE: begin
          if (in_byte == CODE_FONT) begin
            state <= CDWP_FONT;
            font_left <= FONT_BYTES;
          end else if (in_byte == CODE_BRIGHT || in_byte == CODE_POS || in_byte == CODE_CURSOR) begin
            state <= CDWP_ARG;
            pend_cmd <= in_byte;
          end
        end
        CDWP_ARG: state <= CDWP_IDLE;
        CDWP_FONT: begin
          font_left <= font_left - 3'h1; // Font bytes are swallowed, not drawn
          if (font_left == 3'h1) state <= CDWP_IDLE;
        end
        default: state <= CDWP_IDLE;
      endcase
    end
  end

  // Write position, character events and display settings
  logic wrap_flag;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      write_pos <= POS_RESET;
      wrap_flag <= 1'b0;
      char_out <= '0;
      brightness <= BRIGHT_FULL;
      cursor_mode <= CURSOR_OFF;
      all_on <= 1'b0;
      clear_pulse <= 1'b0;
    end else begin
      char_out.valid <= 1'b0;
      clear_pulse <= 1'b0;
      if (take && state == CDWP_ARG) begin
        if (pend_cmd == CODE_POS && in_byte <= {2'b00, POS_LAST}) begin
          write_pos <= in_byte[5:0];
          wrap_flag <= 1'b0;
        end else if (pend_cmd == CODE_BRIGHT) begin
          case (in_byte)
            8'hff: brightness <= 3'h5;
            8'h80: brightness <= 3'h4;
            8'h60: brightness <= 3'h3;
            8'h40: brightness <= 3'h2;
            8'h20: brightness <= 3'h1;
            8'h00: brightness <= 3'h0;
            default: brightness <= brightness;
          endcase
        end else if (pend_cmd == CODE_CURSOR) begin
          case (in_byte)
            8'hff: cursor_mode <= CURSOR_ON;
            8'h88: cursor_mode <= CURSOR_BLINK;
            8'h00: cursor_mode <= CURSOR_OFF;
            default: cursor_mode <= cursor_mode;
          endcase
        end
      end else if (take && state == CDWP_IDLE) begin
        if (!is_ctrl) begin
          char_out.valid <= 1'b1;
          char_out.code <= in_byte;
          char_out.pos <= write_pos;
          char_out.clear_others <= wrap_flag;
          wrap_flag <= write_pos == POS_LAST;
          write_pos <= (write_pos == POS_LAST) ? POS_RESET : write_pos + 6'h1;
        end else if (in_byte == CODE_BS) begin
          write_pos <= (write_pos == POS_RESET) ? POS_LAST : write_pos - 6'h1;
        end else if (in_byte == CODE_TAB) begin
          write_pos <= (write_pos == POS_LAST) ? POS_RESET : write_pos + 6'h1;
        end else if (in_byte == CODE_CLEAR) begin
          write_pos <= POS_RESET;
          clear_pulse <= 1'b1;
          wrap_flag <= 1'b0;
        end else if (in_byte == CODE_ALLON) begin
          all_on <= 1'b1;
          brightness <= BRIGHT_FULL;
        end else if (in_byte == CODE_RESET) begin
          write_pos <= POS_RESET;
          clear_pulse <= 1'b1;
          wrap_flag <= 1'b0;
          all_on <= 1'b0;
          brightness <= BRIGHT_FULL;
          cursor_mode <= CURSOR_ON;
        end
      end
    end
  end

  // Checks
  sequence s_strobe_taken;
    par_take;
  endsequence
  a_busy_after_take: assert property (@(posedge clk) disable iff (!rstn)
    s_strobe_taken |=> busy) else $error("busy not raised after strobe");
  a_busy_length: assert property (@(posedge clk) disable iff (!rstn)
    take |=> busy [*4] ##1 !busy) else $error("busy length wrong");
  a_test_blocks: assert property (@(posedge clk) disable iff (!rstn)
    self_test |=> !char_out.valid && !clear_pulse) else $error("byte taken in self-test");
  a_no_take_busy: assert property (@(posedge clk) disable iff (!rstn)
    busy |=> !char_out.valid && $stable(write_pos)) else $error("byte taken while busy");
  a_char_advance: assert property (@(posedge clk) disable iff (!rstn)
    (take && state == CDWP_IDLE && !is_ctrl && write_pos != POS_LAST) |=> write_pos == $past(write_pos) + 6'h1)
    else $error("position did not advance");
  a_pos_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (take && state == CDWP_IDLE && !is_ctrl && write_pos == POS_LAST) |=> write_pos == POS_RESET && wrap_flag)
    else $error("position did not wrap");
  a_pos_range: assert property (@(posedge clk) disable iff (!rstn)
    write_pos <= POS_LAST) else $error("position out of range");
  a_ctrl_not_char: assert property (@(posedge clk) disable iff (!rstn)
    (take && is_ctrl) |=> !char_out.valid) else $error("control code drawn");
  a_bright_full: assert property (@(posedge clk) disable iff (!rstn)
    (take && state == CDWP_ARG && pend_cmd == CODE_BRIGHT && in_byte == 8'hff) |=> brightness == BRIGHT_FULL)
    else $error("brightness not full");
  a_pos_set: assert property (@(posedge clk) disable iff (!rstn)
    (take && state == CDWP_ARG && pend_cmd == CODE_POS && in_byte == 8'h14) |=> write_pos == POS_ROW2)
    else $error("position command ignored");
endmodule : cdwp_write_port
`default_nettype wire

// >>> cdwp_host_model.sv
// Host processor model driving the parallel write port.
// Assumes one clock shared with the port; select and test are driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module cdwp_host_model (
  input wire logic clk,
  input wire logic busy,
  output logic [7:0] data_pin,
  output logic write_n,
  output logic [7:0] busy_len
);
  // Idle bus with strobe released
  initial begin
    data_pin = 8'h00;
    write_n = 1'b1;
    busy_len = 8'h00;
  end

  // One strobed byte; busy_len reports how long busy stood afterwards
  task automatic send(input logic [7:0] b);
    int n;
    int cnt;
    n = 0;
    cnt = 0;
    while (busy !== 1'b0 && n < 64) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    data_pin <= b;
    repeat (3) @(posedge clk);
    write_n <= 1'b0;
    repeat (3) @(posedge clk);
    write_n <= 1'b1;
    repeat (3) @(posedge clk);
    data_pin <= ~b; // Hold over: stop showing the byte
    @(negedge clk); // Busy settles before counting; avoids a same-edge race
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    while (busy === 1'b1 && cnt < 64) begin
      @(negedge clk);
      cnt++;
    end
    busy_len = 8'(cnt);
  endtask : send
endmodule : cdwp_host_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the display write port.
// Assumes the host model file; serial line held idle since one bit takes >20k cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cdwp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic test_n = 1'b1;
  logic select_n = 1'b0;
  logic baud_fast = 1'b0;
  logic [7:0] data_pin;
  logic write_n;
  logic busy;
  logic self_test;
  logic all_on;
  logic clear_pulse;
  cdwp_char_t char_out;
  logic [5:0] write_pos;
  logic [2:0] brightness;
  logic [1:0] cursor_mode;
  logic [7:0] busy_len;
  logic [14:0] exp_q[$];
  int fails = 0;
  int samples_checked = 0;
  int clears = 0;
  integer seed = 32'h519f;
  logic [5:0] pos = 6'h00;
  logic [7:0] dim_arg[6] = '{8'hff, 8'h80, 8'h60, 8'h40, 8'h20, 8'h00};
  logic [7:0] cur_arg[3] = '{8'h00, 8'hff, 8'h88};
  logic [1:0] cur_exp[3] = '{CURSOR_OFF, CURSOR_ON, CURSOR_BLINK};
  logic [7:0] font[6] = '{8'h1b, 8'h23, 8'h08, 8'h42, 8'h11, 8'hc0};

  always #2.5 clk = ~clk;

  cdwp_write_port DUT (.clk(clk), .rstn(rstn), .data_pin(data_pin), .write_n(write_n), .select_n(select_n),
    .test_n(test_n), .rxd(1'b1), .baud_fast(baud_fast), .busy(busy), .self_test(self_test), .char_out(char_out),
    .write_pos(write_pos), .brightness(brightness), .cursor_mode(cursor_mode), .all_on(all_on),
    .clear_pulse(clear_pulse));
  cdwp_host_model host (.clk(clk), .busy(busy), .data_pin(data_pin), .write_n(write_n), .busy_len(busy_len));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Note the expected character, send it, advance the model position
  task automatic put_char(input logic [7:0] c, input logic clr);
    exp_q.push_back({clr, pos, c});
    host.send(c);
    pos = (pos == 6'h27) ? 6'h00 : pos + 6'h01;
    check("write_pos", 16'(write_pos), 16'(pos));
  endtask : put_char

  // Every stored character must match the oldest note; sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (rstn && clear_pulse === 1'b1) clears++;
    if (rstn && char_out.valid === 1'b1) begin
      if (exp_q.size() == 0) check("char_unexpected", 16'h1, 16'h0);
      else check("char_out", 16'(char_out[14:0]), 16'(exp_q.pop_front()));
    end
  end

  // Watchdog sized well above the 45 byte writes
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    baud_fast <= 1'($random(seed));
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("busy_rst", 16'(busy), 16'h0);
    check("pos_rst", 16'(write_pos), 16'h0);
    check("bright_rst", 16'(brightness), 16'(BRIGHT_FULL));
    check("cursor_rst", {cursor_mode, all_on}, {CURSOR_OFF, 1'b0});
    // Random printable characters
    for (int i = 0; i < 3; i++) begin
      put_char(8'h20 + 8'($random(seed) & 32'h5f), 1'b0);
      check("busy_len", 16'(busy_len), 16'(PROC_CYC));
    end
    // Last digit of row two, wrap, clearing write
    host.send(CODE_POS);
    host.send({2'b00, POS_LAST});
    pos = POS_LAST;
    check("pos_cmd", 16'(write_pos), 16'(pos));
    put_char(8'h41, 1'b0);
    put_char(8'h42, 1'b1);
    host.send(CODE_POS);
    host.send({2'b00, POS_ROW2});
    host.send(CODE_POS);
    host.send(8'h28);
    check("pos_bad", 16'(write_pos), 16'(POS_ROW2));
    host.send(CODE_CLEAR);
    check("pos_clear", 16'(write_pos), 16'h0);
    check("clear_cnt", 16'(clears), 16'h1);
    // Every brightness and cursor argument
    for (int i = 0; i < 6; i++) begin
      host.send(CODE_BRIGHT);
      host.send(dim_arg[i]);
      check("bright", 16'(brightness), 16'(5 - i));
    end
    for (int i = 0; i < 3; i++) begin
      host.send(CODE_CURSOR);
      host.send(cur_arg[i]);
      check("cursor", 16'(cursor_mode), 16'(cur_exp[i]));
    end
    // Back space from the first digit, then tabs
    host.send(CODE_BS);
    check("pos_bs", 16'(write_pos), 16'(POS_LAST));
    host.send(CODE_TAB);
    host.send(CODE_TAB);
    pos = 6'h01;
    check("pos_tab", 16'(write_pos), 16'(pos));
    // Font bytes include 08: must be swallowed as arguments
    host.send(CODE_FONT);
    for (int i = 0; i < 6; i++) host.send(font[i]);
    check("pos_font", 16'(write_pos), 16'(pos));
    // Self-test overrides the port; pins change on the rising edge
    @(posedge clk);
    test_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("self_test", 16'(self_test), 16'h1);
    host.send(8'h55);
    check("test_drop", {8'(busy_len), 2'b00, write_pos}, {8'h00, 2'b00, pos});
    @(posedge clk);
    test_n <= 1'b1;
    // Serial mode ignores the strobe
    select_n <= 1'b1;
    repeat (4) @(posedge clk);
    host.send(8'h56);
    check("serial_drop", {8'(busy_len), 2'b00, write_pos}, {8'h00, 2'b00, pos});
    @(posedge clk);
    select_n <= 1'b0;
    repeat (4) @(posedge clk);
    put_char(8'h57, 1'b0);
    // All-on, then the reset code homes, clears, restores full brightness and turns the cursor on
    host.send(CODE_ALLON);
    check("all_on", 16'(all_on), 16'h1);
    host.send(CODE_RESET);
    check("reset_mode", {all_on, cursor_mode}, {1'b0, CURSOR_ON});
    check("reset_state", {brightness, write_pos}, {BRIGHT_FULL, 6'h00});
    check("reset_clear", 16'(clears), 16'h2);
    check("queue_left", 16'(exp_q.size()), 16'h0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
